// ===== verilog/fet_protection_pkg.sv
// Shared constants, register map and state codes of the fault-report block.
// Assumes a single 100 MHz clock and an APB master with 32-bit data.
package fet_protection_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  // Falling-edge blank time of the hot diode state machine
  localparam int BLANK_NS = 200;
  localparam int BLANK_CYC =
    (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Switch input held low this long resets the short-circuit latch
  localparam int SC_HOLD_NS = 10_000;
  localparam int SC_HOLD_CYC =
    (SC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Stable samples needed before a new drive-strength setting is taken
  localparam int FILTER_CYC = 1024;
  // Cycles after reset release before the straps are captured
  localparam int STRAP_CYC = 4;
  // Temperature output
  localparam int PWM_FREQ_HZ = 9000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int MIN_PULSE_NS = 30;
  localparam int MIN_PULSE_CYC =
    (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // Slew settings in V/ns
  // ************************************************************
  localparam logic [7:0] SLEW_MIN = 8'h0F;
  localparam logic [7:0] SLEW_STEP = 8'h09;
  localparam logic [7:0] SLEW_GND = 8'h96;
  localparam logic [7:0] SLEW_TIE = 8'h64;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] SLEW_OFFSET = 8'h08;
  localparam logic [7:0] PWM_OFFSET = 8'h0C;
  localparam int CTRL_SC_CLEAR_BIT = 0;
  localparam int CTRL_PWM_EN_BIT = 1;
  localparam logic CTRL_PWM_EN_RESET = 1'b1;
  localparam int ST_SW_OT = 0;
  localparam int ST_DRV_OT = 1;
  localparam int ST_UNDERVOLTAGE_LOCKOUT = 2;
  localparam int ST_STARTUP = 3;
  localparam int ST_SC = 4;
  localparam int ST_OC = 5;
  localparam int ST_COMBINED = 6;
  localparam int ST_TIE = 7;
  localparam int ST_GATE = 8;
  localparam int ST_STATE = 12;

  // ************************************************************
  // Hot diode emulation states
  // ************************************************************
  typedef enum logic [3:0] {
    DIODE_OFF = 4'b0001,
    DIODE_BLANK = 4'b0010,
    DIODE_WATCH = 4'b0100,
    DIODE_CONDUCT = 4'b1000
  } diode_state_e;

endpackage

// ===== verilog/fet_protection_fault_report.sv
// Protection sequencing, fault reporting, slew select and temperature PWM.
// Assumes sensing flags arrive synchronous to pclk; the switch input and
// the current-fault pin are asynchronous and are synchronised here.
//
// Behaviour
// R1: Two thermal monitors, switch and driver; driver trips hotter.
// R2: Switch over-temperature runs the switch as a hot ideal diode.
// R3: Driver over-temperature disables aux rail, negative rail and switch.
// R4: Driver over-temperature suppresses diode emulation; switch stays off.
// R5: General fault low while either thermal shutdown is active.
// R6: Normal operation resumes only when both monitors are released.
// R7: Driver shutdown clearing with switch shutdown active resumes diode mode.
// R8: Undervoltage holds switch off, ignores input, general fault low.
// R9: Report code: normal 11, UV/OT/open 01, overcurrent 10, short 00.
// R10: General fault low during start-up until series switch is on.
// R11: Short-circuit or thermal fault holds general fault until cleared.
// R12: Current fault low while overcurrent or short-circuit present.
// R13: Current-fault pin grounded at power-up selects combined reporting.
// R14: Protections act whether or not report outputs are watched.
// R15: Slew from drive pin: resistor 15..150, ground 150, 5 V tie 100.
// R16: 5 V tie checked once at power-up; then pin monitoring stops.
// R17: Otherwise drive pin monitored continuously through heavy filtering.
// R18: Temperature PWM near 9 kHz, minimum pulse about 30 ns.
// R19: Duty maps 25 to 150 degrees onto about 3 to 82 percent.
// R20: Above 150 degrees duty keeps rising linearly until fault.
// R21: Thermal fault holds temperature output high until released.
// R22: Diode mode: off for first quadrant, on for third quadrant.
// R23: Overcurrent turns switch off for this cycle, clears on input low.
// R24: Input falling edge in hot diode mode blanks switch for fixed time.
// R25: Sensing arrives as synchronous flags; PWM from free-running counter.
`timescale 1ns/1ps
`default_nettype none
module fet_protection_fault_report
  import fet_protection_pkg::*;
#(
  parameter int PWM_PERIOD = PWM_PERIOD_CYC,
  parameter int FILTER_LEN = FILTER_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic switch_in,
  input wire logic switch_ot_trip,
  input wire logic switch_ot_release,
  input wire logic driver_ot_trip,
  input wire logic driver_ot_release,
  input wire logic undervoltage_lockout,
  input wire logic aux_5v_good,
  input wire logic neg_rail_good,
  input wire logic series_switch_on,
  input wire logic overcurrent_guard,
  input wire logic short_circuit_guard,
  input wire logic drain_third_quadrant,
  input wire logic drain_first_quadrant,
  input wire logic drive_strength_open,
  input wire logic drive_strength_gnd,
  input wire logic drive_strength_tie,
  input wire logic [3:0] drive_strength_code,
  input wire logic [9:0] temp_duty,
  input wire logic current_fault_in,
  output logic current_fault_n,
  output logic current_fault_oe,
  output logic fault_n,
  output logic switch_gate,
  output logic aux_5v_rail_en,
  output logic negative_gate_rail_en,
  output logic [7:0] slew_rate,
  output logic temp_pwm
);

  // ************************************************************
  // State
  // ************************************************************
  localparam int PWM_W = $clog2(PWM_PERIOD + 1);
  localparam int FILT_W = $clog2(FILTER_LEN + 1);
  localparam int HOLD_W = $clog2(SC_HOLD_CYC + 1);
  localparam int BLANK_W = $clog2(BLANK_CYC + 1);
  localparam int STRAP_W = $clog2(STRAP_CYC + 1);
  localparam logic [PWM_W-1:0] PWM_LAST = PWM_W'(PWM_PERIOD - 1);
  localparam logic [PWM_W-1:0] PWM_MIN = PWM_W'(MIN_PULSE_CYC);
  localparam logic [PWM_W-1:0] PWM_LEN = PWM_W'(PWM_PERIOD);

  typedef struct packed {
    logic [2:0] in_sync;
    logic [2:0] cf_sync;
    logic in_level;
    logic cf_level;
    logic strap_done;
    logic [STRAP_W-1:0] strap_cnt;
    logic combined;
    logic tie_locked;
    logic startup_done;
    logic sw_ot;
    logic drv_ot;
    logic oc_cycle;
    logic sc_latch;
    logic [HOLD_W-1:0] low_cnt;
    diode_state_e diode;
    logic [BLANK_W-1:0] blank_cnt;
    logic [7:0] slew;
    logic [7:0] slew_cand;
    logic [FILT_W-1:0] filt_cnt;
    logic [PWM_W-1:0] pwm_cnt;
    logic [PWM_W-1:0] pwm_thr;
    logic pwm_en;
    logic pwm_out;
    logic gate;
    logic aux_en;
    logic neg_en;
    logic fault_n;
    logic cf_n;
    logic cf_oe;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } state_s;

  state_s s_reg;
  state_s s_next;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [7:0] slew_decode(input logic gnd,
                                             input logic [3:0] code);
    logic [7:0] val;
    val = SLEW_MIN + 8'(code * SLEW_STEP);
    if (gnd) begin
      val = SLEW_GND;
    end
    return val;
  endfunction

  function automatic logic [31:0] status_word(input state_s st,
                                              input logic uv);
    logic [31:0] w;
    w = 32'h0;
    w[ST_SW_OT] = st.sw_ot;
    w[ST_DRV_OT] = st.drv_ot;
    w[ST_UNDERVOLTAGE_LOCKOUT] = uv;
    w[ST_STARTUP] = st.startup_done;
    w[ST_SC] = st.sc_latch;
    w[ST_OC] = st.oc_cycle;
    w[ST_COMBINED] = st.combined;
    w[ST_TIE] = st.tie_locked;
    w[ST_GATE] = st.gate;
    w[ST_STATE +: 4] = st.diode;
    return w;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  logic [PWM_W+9:0] duty_prod;
  logic in_fall;
  logic power_off;
  logic [7:0] slew_in;
  logic apb_wr;
  logic apb_setup;

  always_comb begin
    s_next = s_reg;
    duty_prod = temp_duty * PWM_LEN;
    apb_setup = psel & ~penable;
    apb_wr = psel & penable & pwrite & s_reg.rdy;
    // Pin synchronisers; a level counts when the last two stages agree
    s_next.in_sync = {s_reg.in_sync[1:0], switch_in};
    s_next.cf_sync = {s_reg.cf_sync[1:0], current_fault_in};
    if (s_reg.in_sync[1] == s_reg.in_sync[2]) begin
      s_next.in_level = s_reg.in_sync[2];
    end
    if (s_reg.cf_sync[1] == s_reg.cf_sync[2]) begin
      s_next.cf_level = s_reg.cf_sync[2];
    end
    in_fall = s_reg.in_level & ~s_next.in_level;

    // Straps caught once, after the synchronisers settle
    if (!s_reg.strap_done) begin
      s_next.strap_cnt = s_reg.strap_cnt + 1'b1;
      if (s_reg.strap_cnt == STRAP_W'(STRAP_CYC - 1)) begin
        s_next.strap_done = 1'b1;
        s_next.combined = ~s_next.cf_level; // [R13]
        s_next.tie_locked = drive_strength_tie; // [R16]
      end
    end

    // Start-up completes only with rails up and series switch on
    if (undervoltage_lockout) begin
      s_next.startup_done = 1'b0; // [R8]
    end else if (series_switch_on && aux_5v_good && neg_rail_good &&
                 s_reg.strap_done) begin
      s_next.startup_done = 1'b1; // [R10]
    end

    // Thermal monitors; trip wins over release
    if (switch_ot_release) begin
      s_next.sw_ot = 1'b0; // [R6]
    end
    if (switch_ot_trip) begin
      s_next.sw_ot = 1'b1; // [R1]
    end
    if (driver_ot_release) begin
      s_next.drv_ot = 1'b0; // [R6]
    end
    if (driver_ot_trip) begin
      s_next.drv_ot = 1'b1; // [R1]
    end

    // Overcurrent lasts for the present input cycle only
    if (!s_next.in_level) begin
      s_next.oc_cycle = 1'b0; // [R23]
    end
    if (overcurrent_guard && s_reg.gate) begin
      s_next.oc_cycle = 1'b1; // [R23]
    end

    // Short-circuit latch: reset by long input low or by software
    if (s_next.in_level) begin
      s_next.low_cnt = '0;
    end else if (s_reg.low_cnt != HOLD_W'(SC_HOLD_CYC)) begin
      s_next.low_cnt = s_reg.low_cnt + 1'b1;
    end
    if (s_next.low_cnt == HOLD_W'(SC_HOLD_CYC) ||
        (apb_wr && paddr == CTRL_OFFSET && pwdata[CTRL_SC_CLEAR_BIT])) begin
      s_next.sc_latch = 1'b0; // [R11]
    end
    if (short_circuit_guard) begin
      s_next.sc_latch = 1'b1; // [R11]
    end

    // Hot diode emulation
    case (s_reg.diode)
      DIODE_OFF: begin
        if (s_next.sw_ot && !s_next.drv_ot) begin
          s_next.diode = DIODE_WATCH; // [R2] [R7]
        end
      end
      DIODE_BLANK: begin
        s_next.blank_cnt = s_reg.blank_cnt - 1'b1;
        if (s_reg.blank_cnt == BLANK_W'(1)) begin
          s_next.diode = DIODE_WATCH; // [R24]
        end
      end
      DIODE_WATCH: begin
        if (drain_third_quadrant) begin
          s_next.diode = DIODE_CONDUCT; // [R22]
        end
      end
      DIODE_CONDUCT: begin
        if (drain_first_quadrant) begin
          s_next.diode = DIODE_WATCH; // [R22]
        end
      end
      default: begin
        s_next.diode = DIODE_OFF;
      end
    endcase
    if (s_reg.diode != DIODE_OFF && in_fall) begin
      s_next.diode = DIODE_BLANK; // [R24]
      s_next.blank_cnt = BLANK_W'(BLANK_CYC);
    end
    if (!s_next.sw_ot || s_next.drv_ot) begin
      s_next.diode = DIODE_OFF; // [R4] [R6]
    end

    // Gate drive; protections never depend on the report pins
    power_off = undervoltage_lockout | ~s_next.startup_done |
                s_next.drv_ot | s_next.sc_latch; // [R14]
    if (power_off) begin
      s_next.gate = 1'b0; // [R3] [R4] [R8]
    end else if (s_next.sw_ot) begin
      s_next.gate = (s_next.diode == DIODE_CONDUCT); // [R2] [R22]
    end else begin
      s_next.gate = s_next.in_level & ~s_next.oc_cycle; // [R23]
    end
    s_next.aux_en = ~s_next.drv_ot & ~undervoltage_lockout; // [R3]
    s_next.neg_en = ~s_next.drv_ot & ~undervoltage_lockout; // [R3]

    // Fault report
    s_next.fault_n = ~(undervoltage_lockout | ~s_next.startup_done |
                       s_next.sw_ot | s_next.drv_ot | drive_strength_open |
                       s_next.sc_latch |
                       (s_next.combined & s_next.oc_cycle)); // [R5] [R9]
    s_next.cf_n = s_next.combined |
                  ~(s_next.oc_cycle | s_next.sc_latch); // [R12] [R9]
    // Pin is released while the strap is read or when grounded
    s_next.cf_oe = s_next.strap_done & ~s_next.combined; // [R13]

    // Drive strength select
    slew_in = slew_decode(drive_strength_gnd, drive_strength_code);
    if (s_reg.tie_locked) begin
      s_next.slew = SLEW_TIE; // [R15] [R16]
    end else if (slew_in != s_reg.slew_cand) begin
      s_next.slew_cand = slew_in; // [R17]
      s_next.filt_cnt = '0;
    end else if (s_reg.filt_cnt == FILT_W'(FILTER_LEN - 1)) begin
      s_next.slew = s_reg.slew_cand; // [R15] [R17]
    end else begin
      s_next.filt_cnt = s_reg.filt_cnt + 1'b1;
    end

    // Temperature PWM; threshold refreshed once per period
    if (s_reg.pwm_cnt == PWM_LAST) begin
      s_next.pwm_cnt = '0; // [R18] [R25]
      s_next.pwm_thr = duty_prod[PWM_W+9:10]; // [R19] [R20]
      if (duty_prod[PWM_W+9:10] < PWM_MIN) begin
        s_next.pwm_thr = PWM_MIN; // [R18]
      end
    end else begin
      s_next.pwm_cnt = s_reg.pwm_cnt + 1'b1;
    end
    if (s_reg.sw_ot || s_reg.drv_ot) begin
      s_next.pwm_out = 1'b1; // [R21]
    end else begin
      s_next.pwm_out = s_reg.pwm_en & (s_reg.pwm_cnt < s_reg.pwm_thr);
    end

    // APB slave: answer in the first access cycle
    s_next.rdy = apb_setup;
    s_next.err = 1'b0;
    if (apb_setup) begin
      case (paddr)
        CTRL_OFFSET: s_next.rdata = 32'(s_reg.pwm_en) << CTRL_PWM_EN_BIT;
        STATUS_OFFSET: s_next.rdata = status_word(s_reg,
                                                  undervoltage_lockout);
        SLEW_OFFSET: s_next.rdata = {24'h0, s_reg.slew};
        PWM_OFFSET: s_next.rdata = 32'(s_reg.pwm_thr);
        default: begin
          s_next.rdata = 32'h0;
          s_next.err = 1'b1;
        end
      endcase
    end
    if (apb_wr && paddr == CTRL_OFFSET) begin
      s_next.pwm_en = pwdata[CTRL_PWM_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.in_level <= 1'b0;
      s_reg.cf_level <= 1'b1;
      s_reg.cf_sync <= 3'h7;
      s_reg.diode <= DIODE_OFF;
      s_reg.slew <= SLEW_GND;
      s_reg.slew_cand <= SLEW_GND;
      s_reg.pwm_thr <= PWM_MIN;
      s_reg.pwm_en <= CTRL_PWM_EN_RESET;
      s_reg.cf_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.rdata;
  assign pready = s_reg.rdy;
  assign pslverr = s_reg.err;
  assign current_fault_n = s_reg.cf_n;
  assign current_fault_oe = s_reg.cf_oe;
  assign fault_n = s_reg.fault_n;
  assign switch_gate = s_reg.gate;
  assign aux_5v_rail_en = s_reg.aux_en;
  assign negative_gate_rail_en = s_reg.neg_en;
  assign slew_rate = s_reg.slew;
  assign temp_pwm = s_reg.pwm_out;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_thermal_held;
    (s_reg.sw_ot || s_reg.drv_ot) ##1 (s_reg.sw_ot || s_reg.drv_ot);
  endsequence

  sequence s_blank_entry;
    (s_reg.diode != DIODE_BLANK) ##1 (s_reg.diode == DIODE_BLANK);
  endsequence

  a_thermal_fault: assert property ( // [R5]
    (s_reg.sw_ot || s_reg.drv_ot) |-> !fault_n)
    else $error("general fault high during thermal shutdown");

  a_undervoltage_lockout_off: assert property ( // [R8]
    undervoltage_lockout |=> !switch_gate && !fault_n)
    else $error("switch on or fault high under undervoltage");

  a_driver_ot_off: assert property ( // [R3]
    s_reg.drv_ot |-> !aux_5v_rail_en && !negative_gate_rail_en &&
                     !switch_gate)
    else $error("rails or switch on in driver shutdown");

  a_diode_gate: assert property ( // [R22]
    (s_reg.diode != DIODE_OFF && s_reg.startup_done && !s_reg.sc_latch) |->
    switch_gate == (s_reg.diode == DIODE_CONDUCT))
    else $error("gate disagrees with diode state");

  a_blank_hold: assert property ( // [R24]
    s_blank_entry |-> (!switch_gate && s_reg.diode == DIODE_BLANK) [*8])
    else $error("blank state left early or gate on");

  a_oc_report: assert property ( // [R12]
    (s_reg.oc_cycle && !s_reg.combined && s_reg.strap_done) |->
    !current_fault_n)
    else $error("current fault not low on overcurrent");

  a_sc_both_low: assert property ( // [R9]
    (s_reg.sc_latch && !s_reg.combined) |-> !fault_n && !current_fault_n)
    else $error("short-circuit report code wrong");

  a_startup_fault: assert property ( // [R10]
    !s_reg.startup_done |-> !fault_n)
    else $error("fault released before start-up done");

  a_pwm_hot: assert property ( // [R21]
    s_thermal_held |=> temp_pwm)
    else $error("temperature output not high in thermal fault");

  a_tie_slew: assert property ( // [R16]
    s_reg.tie_locked |=> slew_rate == SLEW_TIE && $stable(s_reg.tie_locked))
    else $error("slew not fixed after 5 V tie");

  a_apb_ready: assert property (
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer not in first access cycle");

endmodule
`default_nettype wire

// ===== bench/ctrl_model.sv
// Converter controller model: drives the switch command, reads the report pin.
// Assumes pclk from the bench and a pull-up on its current-fault input.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input wire logic pclk,
  input wire logic cmd,
  input wire logic gnd_strap,
  input wire logic current_fault_n,
  input wire logic current_fault_oe,
  output logic switch_in,
  output logic current_fault_in
);
  // ****************************
  // Command and pin level
  // ****************************
  initial switch_in = 1'h0;
  // Command moves just after the edge, as a real controller would
  always @(posedge pclk) begin
    switch_in <= cmd;
  end
  // Grounded pin wins; pull-up reads high while nobody drives
  assign current_fault_in = gnd_strap ? 1'h0 :
    (current_fault_oe ? current_fault_n : 1'h1);
endmodule
`default_nettype wire

// ===== bench/fet_protection_fault_report_tb.sv
// Self-checking bench of the fault-report block.
// Assumes the controller model beside it and short PWM and filter counts.
`timescale 1ns/1ps
`default_nettype none
module fet_protection_fault_report_tb;
  import fet_protection_pkg::*;
  // ****************************
  // Signals
  // ****************************
  localparam int PER = 64;
  localparam int SOT = 0, SOR = 1, DOT = 2, DOR = 3, OCG = 4, SCG = 5;
  localparam int TQ = 6, FQ = 7, UV = 8, OPN = 9, GND = 10, SER = 11;
  localparam int CMD = 12;
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;
  typedef struct packed {logic [32:0] v; logic [32:0] m;} note_s;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [12:0] fl = 13'h0;
  logic [3:0] code = 4'h0;
  logic [9:0] duty = 10'h000;
  logic gnd_strap = 1'h0;
  logic tie = 1'h0;
  logic chk = 1'h0;
  logic [7:0] exp_slew = 8'h0F;
  logic [7:0] rnd = 8'h47;
  logic [31:0] prdata;
  logic pready, pslverr, switch_in, current_fault_in, current_fault_n;
  logic current_fault_oe, fault_n, switch_gate, aux_5v_rail_en;
  logic negative_gate_rail_en, temp_pwm;
  logic [7:0] slew_rate;
  note_s rdq[$];
  note_s pinq[$];
  note_s nt;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  always #5 pclk = ~pclk;

  fet_protection_fault_report #(.PWM_PERIOD(PER), .FILTER_LEN(8)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .switch_in, .switch_ot_trip(fl[SOT]),
    .switch_ot_release(fl[SOR]), .driver_ot_trip(fl[DOT]),
    .driver_ot_release(fl[DOR]), .undervoltage_lockout(fl[UV]),
    .aux_5v_good(1'h1), .neg_rail_good(1'h1), .series_switch_on(fl[SER]),
    .overcurrent_guard(fl[OCG]), .short_circuit_guard(fl[SCG]),
    .drain_third_quadrant(fl[TQ]), .drain_first_quadrant(fl[FQ]),
    .drive_strength_open(fl[OPN]), .drive_strength_gnd(fl[GND]),
    .drive_strength_tie(tie), .drive_strength_code(code),
    .temp_duty(duty), .current_fault_in, .current_fault_n,
    .current_fault_oe, .fault_n, .switch_gate, .aux_5v_rail_en,
    .negative_gate_rail_en, .slew_rate, .temp_pwm
  );

  ctrl_model partner (
    .pclk, .cmd(fl[CMD]), .gnd_strap, .current_fault_n, .current_fault_oe,
    .switch_in, .current_fault_in
  );

  // ****************************
  // Tasks
  // ****************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [32:0] g, input logic [32:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic lvl(input int k, input logic v);
    @(posedge pclk);
    fl[k] <= v;
  endtask

  task automatic pulse(input int k);
    lvl(k, 1'h1);
    lvl(k, 1'h0);
  endtask

  // Bits: pwm, oe, fault, current fault, gate, aux rail, negative rail
  task automatic pin(input logic [6:0] e, input logic [6:0] m,
                     input int w = 12);
    tick(w);
    pinq.push_back({{18'h0, e, exp_slew}, {18'h0, m, 8'hFF}});
    chk <= 1'h1;
    @(posedge pclk);
    chk <= 1'h0;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e,
                    input logic [32:0] m);
    rdq.push_back({e, m});
    apb(1'h0, a, 32'h0);
  endtask

  // ****************************
  // Monitor and timeout
  // ****************************
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && rdq.size() > 0) begin
      nt = rdq.pop_front();
      check({pslverr, prdata} & nt.m, nt.v & nt.m);
    end
    if (chk && pinq.size() > 0) begin
      nt = pinq.pop_front();
      check({18'h0, temp_pwm, current_fault_oe, fault_n, current_fault_n,
        switch_gate, aux_5v_rail_en, negative_gate_rail_en, slew_rate} & nt.m,
        nt.v & nt.m);
    end
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      stop_test();
    end
  end

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    tick(6);
    presetn <= 1'h1;
    pin(7'h00, 7'h14, 16);
    lvl(SER, 1'h1);
    pin(7'h3B, 7'h3F);
    rd(CTRL_OFFSET, 33'h2, ALL);
    rd(8'h10, {1'h1, 32'h0}, ALL);
    lvl(CMD, 1'h1);
    pin(7'h3F, 7'h3F);
    pulse(OCG);
    pin(7'h33, 7'h3F);
    lvl(CMD, 1'h0);
    pin(7'h3B, 7'h3F);
    lvl(CMD, 1'h1);
    tick(8);
    pulse(SCG);
    pin(7'h23, 7'h3F);
    rd(STATUS_OFFSET, 33'h1 << ST_SC, 33'h1 << ST_SC);
    lvl(CMD, 1'h0);
    pin(7'h23, 7'h3F, 20);
    apb(1'h1, CTRL_OFFSET, 32'h3);
    pin(7'h3B, 7'h3F);
    pulse(SOT);
    pin(7'h6B, 7'h7F);
    lvl(TQ, 1'h1);
    pin(7'h6F, 7'h7F);
    lvl(TQ, 1'h0);
    lvl(FQ, 1'h1);
    pin(7'h6B, 7'h7F);
    lvl(FQ, 1'h0);
    lvl(TQ, 1'h1);
    pin(7'h6F, 7'h7F);
    lvl(CMD, 1'h1);
    tick(8);
    lvl(CMD, 1'h0);
    pin(7'h6B, 7'h7F, 8);
    pin(7'h6F, 7'h7F, 30);
    pulse(DOT);
    pin(7'h68, 7'h7F);
    pulse(DOR);
    pin(7'h6F, 7'h7F);
    pulse(DOT);
    pulse(SOR);
    pin(7'h68, 7'h7F);
    pulse(DOR);
    pin(7'h3B, 7'h3F);
    lvl(TQ, 1'h0);
    lvl(CMD, 1'h1);
    lvl(UV, 1'h1);
    pin(7'h08, 7'h1C);
    lvl(UV, 1'h0);
    pin(7'h3F, 7'h3F, 20);
    lvl(CMD, 1'h0);
    lvl(OPN, 1'h1);
    pin(7'h08, 7'h18);
    lvl(OPN, 1'h0);
    // Code held far longer than the filter; the pin may only move slowly
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      @(posedge pclk);
      code <= rnd[3:0];
      exp_slew = SLEW_MIN + SLEW_STEP * {4'h0, rnd[3:0]};
      pin(7'h3B, 7'h3F, 30);
    end
    lvl(GND, 1'h1);
    exp_slew = SLEW_GND;
    pin(7'h3B, 7'h3F, 30);
    apb(1'h1, SLEW_OFFSET, 32'h0);
    rd(SLEW_OFFSET, {25'h0, SLEW_GND}, ALL);
    rnd = lfsr(rnd);
    @(posedge pclk);
    duty <= {1'h1, rnd, 1'h0};
    tick(3 * PER);
    rd(PWM_OFFSET, 33'(({1'h1, rnd, 1'h0} * PER) / 1024), ALL);
    // Second power-up with the report pin grounded
    @(posedge pclk);
    gnd_strap <= 1'h1;
    presetn <= 1'h0;
    tick(6);
    presetn <= 1'h1;
    pin(7'h1B, 7'h3F, 30);
    lvl(CMD, 1'h1);
    pin(7'h1F, 7'h3F);
    pulse(OCG);
    pin(7'h0B, 7'h3F);
    lvl(CMD, 1'h0);
    // Third power-up with the drive pin tied to the 5 V rail
    @(posedge pclk);
    tie <= 1'h1;
    presetn <= 1'h0;
    tick(6);
    presetn <= 1'h1;
    exp_slew = SLEW_TIE;
    pin(7'h1B, 7'h3F, 30);
    lvl(GND, 1'h0);
    @(posedge pclk);
    code <= 4'h3;
    pin(7'h1B, 7'h3F, 30);
    stop_test();
  end
endmodule
`default_nettype wire
